// File: hdl/smbus_alert_pkg.sv
// Purpose: Shared constants and helpers for both ends of the link.
// Assumes: core_clk runs at 50 MHz on both ends.
// Notes:   Host register offsets and fields are local choices.
package smbus_alert_pkg;
  // Clocking of the bus made by the host.
  localparam int         CLK_NS       = 20;
  localparam int         SCL_HALF_NS  = 5000;
  localparam logic [7:0] SCL_HALF_CYC = 8'(SCL_HALF_NS / CLK_NS);
  localparam logic [7:0] SCL_QTR_CYC  = 8'(SCL_HALF_NS / CLK_NS / 2);
  // Bus addresses and commands.
  localparam logic [6:0] ARA_ADDR        = 7'h0c;
  localparam logic [7:0] CMD_CLEAR_FAULT = 8'h03;
  localparam logic [7:0] CMD_ALERT_MASK  = 8'hd8;
  localparam logic [15:0] ALERT_MASK_RST = 16'h0000;
  // Strap ranks and decoded address bases.
  localparam logic [1:0] STRAP_OPEN = 2'h0;
  localparam logic [1:0] STRAP_LOW  = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h2;
  localparam logic [6:0] ADDR_BASE_A = 7'h40;
  localparam logic [6:0] ADDR_BASE_B = 7'h10;
  localparam logic [6:0] ADDR_BASE_C = 7'h50;
  // Host register offsets.
  localparam logic [2:0] REG_CTRL     = 3'h0;
  localparam logic [2:0] REG_DATA     = 3'h1;
  localparam logic [2:0] REG_SLOPE    = 3'h2;
  localparam logic [2:0] REG_OFFS     = 3'h3;
  localparam logic [2:0] REG_EXP      = 3'h4;
  localparam logic [2:0] REG_STATUS   = 3'h5;
  localparam logic [2:0] REG_INT_STAT = 3'h6;
  localparam logic [2:0] REG_INT_MASK = 3'h7;
  // Host operations in CTRL[1:0]; target address in CTRL[8:2].
  localparam logic [1:0] OP_CLEAR = 2'h0;
  localparam logic [1:0] OP_MASK  = 2'h1;
  localparam logic [1:0] OP_ARA   = 2'h2;
  localparam logic [1:0] OP_VALUE = 2'h3;
  // Interrupt status bits.
  localparam int INT_DONE  = 0;
  localparam int INT_ALERT = 1;

  // Ranks one strap from its two level sensors.
  function automatic logic [1:0] strap_rank(input logic hi, input logic lo);
    return hi ? STRAP_HIGH : (lo ? STRAP_LOW : STRAP_OPEN);
  endfunction

  // Maps three strap ranks onto one of 27 target addresses.
  function automatic logic [6:0] strap_addr(input logic [1:0] r2,
                                            input logic [1:0] r1,
                                            input logic [1:0] r0);
    logic [6:0] idx;
    idx = 7'(r2) * 7'h9 + 7'(r1) * 7'h3 + 7'(r0);
    if (idx < 7'h8)
      return ADDR_BASE_A + idx;
    else if (idx < 7'h10)
      return ADDR_BASE_B + idx - 7'h8;
    else
      return ADDR_BASE_C + idx - 7'h10;
  endfunction

  // Encodes a real value as (m*x + b) * 10^r, r limited to +/-7.
  function automatic logic [15:0] direct_encode(input logic signed [15:0] x,
                                                input logic signed [15:0] m,
                                                input logic signed [15:0] b,
                                                input logic signed [7:0] r);
    logic signed [39:0] acc;
    acc = 40'(m) * 40'(x) + 40'(b);
    for (int i = 0; i < 7; i++) begin
      if (r > i)
        acc = acc * 40'sha;
      else if (-r > i)
        acc = acc / 40'sha;
    end
    return acc[15:0];
  endfunction
endpackage

// File: hdl/smbus_link_if.sv
// Purpose: Two-wire bus plus shared alert line between host and device.
// Assumes: Open-drain lines resolve as a wired AND.
// Notes:   Enables are active low; a driven pin carries its out value.
`timescale 1ns/1ns
interface smbus_link_if;
  logic scl;
  logic host_sda_out;
  logic host_sda_oe_n;
  logic dev_sda_out;
  logic dev_sda_oe_n;
  logic dev_alert_out;
  logic dev_alert_oe_n;
  logic sda;
  logic alert_line;

  // Wired AND of the open-drain drivers, released lines pull high.
  assign sda = (host_sda_oe_n | host_sda_out)
             & (dev_sda_oe_n | dev_sda_out);
  assign alert_line = dev_alert_oe_n | dev_alert_out;

  modport host (output scl, host_sda_out, host_sda_oe_n,
                input  sda, alert_line);
  modport device (input  scl, sda,
                  output dev_sda_out, dev_sda_oe_n,
                  output dev_alert_out, dev_alert_oe_n);
endinterface

// File: hdl/smbus_alert_dev.sv
// Purpose: Target end: strap decode, alert mask register, automatic mask.
// Assumes: Fault levels come from logic on core_clk; bus pins are async.
// Notes:   Alert line low means asserted; sda driven low only.
`timescale 1ns/1ns
module smbus_alert_dev
  import smbus_alert_pkg::*;
(
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // Strap level sensors, one pair per strap pin.
  input  wire logic [2:0]  strap_hi,
  input  wire logic [2:0]  strap_lo,
  // Fault and warning levels, visible at all times.
  input  wire logic [15:0] fault,
  // State shown to local logic.
  output logic [6:0]       own_addr,
  output logic [15:0]      alert_mask,
  output logic [15:0]      auto_alert_mask,
  output logic             alert_active,
  // Bus side.
  smbus_link_if.device     link
);
  typedef enum logic [4:0] {
    D_IDLE = 5'h01,
    D_RX   = 5'h02,
    D_ACK  = 5'h04,
    D_TX   = 5'h08,
    D_SKIP = 5'h10
  } dev_state_e;

  typedef struct packed {
    logic        scl_s1;
    logic        scl_s2;
    logic        scl_d;
    logic        sda_s1;
    logic        sda_s2;
    logic        sda_d;
    logic [2:0]  hi_s1;
    logic [2:0]  hi_s2;
    logic [2:0]  lo_s1;
    logic [2:0]  lo_s2;
    logic [1:0]  cap_cnt;
    logic [6:0]  addr;
    dev_state_e  state;
    logic [3:0]  bit_cnt;
    logic [7:0]  shreg;
    logic [1:0]  byte_idx;
    logic [7:0]  cmd;
    logic [7:0]  mask_lo;
    logic        is_ara;
    logic [15:0] alert_mask;
    logic [15:0] auto_mask;
    logic        sda_oe_n;
    logic        alert_oe_n;
  } dev_s;

  dev_s s;
  dev_s next_s;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  // Edges and bus conditions, seen only behind the second sync stage.
  assign scl_rise  = s.scl_s2 & ~s.scl_d;
  assign scl_fall  = ~s.scl_s2 & s.scl_d;
  assign bus_start = s.scl_s2 & s.scl_d & s.sda_d & ~s.sda_s2;
  assign bus_stop  = s.scl_s2 & s.scl_d & ~s.sda_d & s.sda_s2;

  // Next-state logic for the whole target end.
  always_comb begin
    next_s        = s;
    next_s.scl_s1 = link.scl;
    next_s.scl_s2 = s.scl_s1;
    next_s.scl_d  = s.scl_s2;
    next_s.sda_s1 = link.sda;
    next_s.sda_s2 = s.sda_s1;
    next_s.sda_d  = s.sda_s2;
    next_s.hi_s1  = strap_hi;
    next_s.hi_s2  = s.hi_s1;
    next_s.lo_s1  = strap_lo;
    next_s.lo_s2  = s.lo_s1;

    // Latch straps
    // Straps are caught once, after the sync stages have filled.
    if (s.cap_cnt != 2'h3) begin
      next_s.cap_cnt = s.cap_cnt + 2'h1;
      if (s.cap_cnt == 2'h2)
        next_s.addr = strap_addr(strap_rank(s.hi_s2[2], s.lo_s2[2]),
                                 strap_rank(s.hi_s2[1], s.lo_s2[1]),
                                 strap_rank(s.hi_s2[0], s.lo_s2[0]));
    end

    // Gate alert line
    // Faults raise the line unless either mask covers them.
    next_s.alert_oe_n = ~|(fault & ~s.alert_mask & ~s.auto_mask);

    // Bus conditions override every state.
    if (bus_stop) begin
      next_s.state    = D_IDLE;
      next_s.sda_oe_n = 1'b1;
    end else if (bus_start) begin
      next_s.state    = D_RX;
      next_s.bit_cnt  = 4'h0;
      next_s.byte_idx = 2'h0;
      next_s.is_ara   = 1'b0;
      next_s.sda_oe_n = 1'b1;
    end else begin
      unique case (s.state)
        D_IDLE: next_s.sda_oe_n = 1'b1;
        D_RX: begin
          if (scl_rise) begin
            next_s.shreg   = {s.shreg[6:0], s.sda_s2};
            next_s.bit_cnt = s.bit_cnt + 4'h1;
          end else if (scl_fall && s.bit_cnt == 4'h8) begin
            next_s.bit_cnt  = 4'h0;
            next_s.state    = D_ACK;
            next_s.sda_oe_n = 1'b0;
            unique case (s.byte_idx)
              2'h0: begin
                if (s.shreg == {s.addr, 1'b0}) begin
                  next_s.is_ara = 1'b0;
                end else if (s.shreg == {ARA_ADDR, 1'b1} &&
                             !s.alert_oe_n) begin
                  next_s.is_ara = 1'b1;
                end else begin
                  next_s.state    = D_SKIP;
                  next_s.sda_oe_n = 1'b1;
                end
              end
              2'h1: begin
                next_s.cmd = s.shreg;
                if (s.shreg == CMD_CLEAR_FAULT) begin
                  next_s.auto_mask = 16'h0000;
                end else if (s.shreg != CMD_ALERT_MASK) begin
                  next_s.state    = D_SKIP;
                  next_s.sda_oe_n = 1'b1;
                end
              end
              2'h2: begin
                next_s.mask_lo = s.shreg;
                if (s.cmd != CMD_ALERT_MASK) begin
                  next_s.state    = D_SKIP;
                  next_s.sda_oe_n = 1'b1;
                end
              end
              default: begin
                next_s.alert_mask = {s.shreg, s.mask_lo};
              end
            endcase
          end
        end
        D_ACK: begin
          if (scl_fall) begin
            if (s.is_ara) begin
              // Drive the first reply bit; a zero pulls sda low.
              next_s.state    = D_TX;
              next_s.shreg    = {s.addr, 1'b0};
              next_s.sda_oe_n = s.addr[6];
            end else if (s.byte_idx == 2'h3) begin
              next_s.state    = D_SKIP;
              next_s.sda_oe_n = 1'b1;
            end else begin
              next_s.state    = D_RX;
              next_s.byte_idx = s.byte_idx + 2'h1;
              next_s.sda_oe_n = 1'b1;
            end
          end
        end
        D_TX: begin
          if (scl_rise) begin
            if (s.sda_oe_n && !s.sda_s2) begin
              next_s.state = D_SKIP;
            end else begin
              next_s.bit_cnt = s.bit_cnt + 4'h1;
              next_s.shreg   = {s.shreg[6:0], 1'b0};
            end
          end else if (scl_fall) begin
            if (s.bit_cnt == 4'h8) begin
              next_s.state    = D_SKIP;
              next_s.sda_oe_n = 1'b1;
              // Set auto mask
              // Status stays on the fault inputs; only alert is gated.
              next_s.auto_mask = s.auto_mask | fault;
            end else begin
              next_s.sda_oe_n = s.shreg[7];
            end
          end
        end
        D_SKIP: next_s.sda_oe_n = 1'b1;
      endcase
    end
  end

  // State register.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s            <= '0;
      s.scl_s1     <= 1'b1;
      s.scl_s2     <= 1'b1;
      s.scl_d      <= 1'b1;
      s.sda_s1     <= 1'b1;
      s.sda_s2     <= 1'b1;
      s.sda_d      <= 1'b1;
      s.state      <= D_IDLE;
      s.alert_mask <= ALERT_MASK_RST;
      s.sda_oe_n   <= 1'b1;
      s.alert_oe_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs taken straight from the state register.
  assign own_addr            = s.addr;
  assign alert_mask          = s.alert_mask;
  assign auto_alert_mask     = s.auto_mask;
  assign alert_active        = ~s.alert_oe_n;
  assign link.dev_sda_out    = 1'b0;
  assign link.dev_sda_oe_n   = s.sda_oe_n;
  assign link.dev_alert_out  = 1'b0;
  assign link.dev_alert_oe_n = s.alert_oe_n;
endmodule

// File: hdl/smbus_alert_host.sv
// Purpose: Host end: runs clear-fault, mask write and alert response.
// Assumes: Software uses the plain register port on core_clk.
// Notes:   Bus clock is divided from core_clk and driven push-pull.
`timescale 1ns/1ns
module smbus_alert_host
  import smbus_alert_pkg::*;
(
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // Register port.
  input  wire logic [2:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  output logic             irq,
  // Bus side.
  smbus_link_if.host       link
);
  typedef enum logic [4:0] {
    H_IDLE  = 5'h01,
    H_START = 5'h02,
    H_LOW   = 5'h04,
    H_HIGH  = 5'h08,
    H_STOP  = 5'h10
  } host_state_e;

  typedef struct packed {
    host_state_e state;
    logic [7:0]  timer;
    logic        stop_ph;
    logic        scl;
    logic        sda_oe_n;
    logic [31:0] frame;
    logic [1:0]  last;
    logic [1:0]  byte_idx;
    logic [3:0]  bit_cnt;
    logic        rd;
    logic        rxing;
    logic [7:0]  rx;
    logic        nack;
    logic [6:0]  target;
    logic [15:0] data;
    logic [15:0] slope;
    logic [15:0] offs;
    logic [7:0]  expo;
    logic [1:0]  int_stat;
    logic [1:0]  int_mask;
    logic        sda_s1;
    logic        sda_s2;
    logic        alr_s1;
    logic        alr_s2;
    logic        alr_d;
    logic [15:0] rdata;
    logic        irq;
  } host_s;

  host_s s;
  host_s next_s;
  logic  busy;
  logic  [15:0] word;
  logic  [1:0] ev;

  assign busy = ~s.state[0];

  // Value encoding
  // Raw mask write or a value encoded from 16-bit terms and 8-bit exponent.
  assign word = direct_encode(s.data, s.slope, s.offs, s.expo);

  // Next-state logic for the host end.
  always_comb begin
    next_s        = s;
    ev            = 2'h0;
    next_s.sda_s1 = link.sda;
    next_s.sda_s2 = s.sda_s1;
    next_s.alr_s1 = link.alert_line;
    next_s.alr_s2 = s.alr_s1;
    next_s.alr_d  = s.alr_s2;
    next_s.timer  = s.timer + 8'h1;
    ev[INT_ALERT] = s.alr_d & ~s.alr_s2;

    // Register writes; a CTRL write while busy is ignored.
    if (reg_wr) begin
      unique case (reg_addr)
        REG_CTRL: if (!busy) begin
          next_s.state    = H_START;
          next_s.timer    = 8'h0;
          next_s.sda_oe_n = 1'b0;
          next_s.target   = reg_wdata[8:2];
          next_s.nack     = 1'b0;
          next_s.byte_idx = 2'h0;
          next_s.bit_cnt  = 4'h0;
          next_s.rxing    = 1'b0;
          next_s.rd       = reg_wdata[1:0] == OP_ARA;
          unique case (reg_wdata[1:0])
            OP_CLEAR: begin
              next_s.frame = {reg_wdata[8:2], 1'b0, CMD_CLEAR_FAULT,
                              16'h0000};
              next_s.last  = 2'h1;
            end
            OP_ARA: begin
              next_s.frame = {ARA_ADDR, 1'b1, 24'h000000};
              next_s.last  = 2'h0;
            end
            OP_MASK: begin
              next_s.frame = {reg_wdata[8:2], 1'b0, CMD_ALERT_MASK,
                              s.data[7:0], s.data[15:8]};
              next_s.last  = 2'h3;
            end
            default: begin
              next_s.frame = {reg_wdata[8:2], 1'b0, CMD_ALERT_MASK,
                              word[7:0], word[15:8]};
              next_s.last  = 2'h3;
            end
          endcase
        end
        REG_DATA:     next_s.data     = reg_wdata;
        REG_SLOPE:    next_s.slope    = reg_wdata;
        REG_OFFS:     next_s.offs     = reg_wdata;
        REG_EXP:      next_s.expo     = reg_wdata[7:0];
        REG_INT_MASK: next_s.int_mask = reg_wdata[1:0];
        default: ;
      endcase
    end

    // Bus sequencing, one half period per clock phase.
    unique case (s.state)
      H_IDLE: begin
        next_s.scl      = 1'b1;
        next_s.sda_oe_n = next_s.sda_oe_n;
      end
      H_START: if (s.timer == SCL_HALF_CYC) begin
        next_s.state = H_LOW;
        next_s.scl   = 1'b0;
        next_s.timer = 8'h0;
      end
      H_LOW: begin
        // Data changes mid-low so it never moves near an scl edge.
        if (s.timer == SCL_QTR_CYC)
          next_s.sda_oe_n = (s.rxing || s.bit_cnt == 4'h8) ? 1'b1
                                                            : s.frame[31];
        if (s.timer == SCL_HALF_CYC) begin
          next_s.state = H_HIGH;
          next_s.scl   = 1'b1;
          next_s.timer = 8'h0;
        end
      end
      H_HIGH: if (s.timer == SCL_HALF_CYC) begin
        next_s.scl   = 1'b0;
        next_s.timer = 8'h0;
        next_s.state = H_LOW;
        if (s.bit_cnt != 4'h8) begin
          next_s.bit_cnt = s.bit_cnt + 4'h1;
          next_s.frame   = {s.frame[30:0], 1'b0};
          next_s.rx      = {s.rx[6:0], s.sda_s2};
        end else begin
          next_s.bit_cnt = 4'h0;
          if (s.rxing || s.sda_s2 || s.byte_idx == s.last) begin
            next_s.nack  = !s.rxing && s.sda_s2;
            next_s.rxing = s.rd && !s.rxing && !s.sda_s2;
            if (!next_s.rxing) begin
              next_s.state   = H_STOP;
              next_s.stop_ph = 1'b0;
            end
          end else begin
            next_s.byte_idx = s.byte_idx + 2'h1;
          end
        end
      end
      H_STOP: begin
        if (!s.stop_ph && s.timer == SCL_QTR_CYC)
          next_s.sda_oe_n = 1'b0;
        if (s.timer == SCL_HALF_CYC) begin
          next_s.timer = 8'h0;
          if (!s.stop_ph) begin
            next_s.scl     = 1'b1;
            next_s.stop_ph = 1'b1;
          end else begin
            next_s.sda_oe_n = 1'b1;
            next_s.state    = H_IDLE;
            ev[INT_DONE]    = 1'b1;
          end
        end
      end
    endcase

    // Read data one cycle later; status events win over the read clear.
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL:     next_s.rdata = {7'h00, s.target, 2'h0};
        REG_DATA:     next_s.rdata = s.data;
        REG_SLOPE:    next_s.rdata = s.slope;
        REG_OFFS:     next_s.rdata = s.offs;
        REG_EXP:      next_s.rdata = {8'h00, s.expo};
        REG_STATUS:   next_s.rdata = {s.rx, 4'h0, ~s.alr_s2, s.nack,
                                      1'b0, busy};
        REG_INT_STAT: next_s.rdata = {14'h0000, s.int_stat};
        default:      next_s.rdata = {14'h0000, s.int_mask};
      endcase
    end
    next_s.int_stat = ((reg_rd && reg_addr == REG_INT_STAT) ? 2'h0
                                                            : s.int_stat)
                    | ev;
    next_s.irq = |(next_s.int_stat & s.int_mask);
  end

  // State register.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s          <= '0;
      s.state    <= H_IDLE;
      s.scl      <= 1'b1;
      s.sda_oe_n <= 1'b1;
      s.sda_s1   <= 1'b1;
      s.sda_s2   <= 1'b1;
      s.alr_s1   <= 1'b1;
      s.alr_s2   <= 1'b1;
      s.alr_d    <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs taken straight from the state register.
  assign reg_rdata          = s.rdata;
  assign irq                = s.irq;
  assign link.scl           = s.scl;
  assign link.host_sda_out  = 1'b0;
  assign link.host_sda_oe_n = s.sda_oe_n;
endmodule

// File: tb/smbus_alert_checker.sv
// Purpose: Assertions on the link and on the alert state of the device end.
// Assumes: One device on the link; everything runs on core_clk.
// Notes:   Alert relations use the registered one-cycle update.
`timescale 1ns/1ns
module smbus_alert_checker
  import smbus_alert_pkg::*;
(
  // Clock and reset.
  input wire logic        core_clk,
  input wire logic        arst_n,
  // Link signals.
  input wire logic        scl,
  input wire logic        dev_sda_out,
  input wire logic        dev_sda_oe_n,
  input wire logic        dev_alert_out,
  input wire logic        dev_alert_oe_n,
  // Device fault and mask state.
  input wire logic [15:0] fault,
  input wire logic [15:0] alert_mask,
  input wire logic [15:0] auto_alert_mask
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic [15:0] live;
  // Faults that neither mask hides.
  assign live = fault & ~alert_mask & ~auto_alert_mask;

  property p_alert_on;
    live != 16'h0 |=> !dev_alert_oe_n;
  endproperty
  a_alert_on: assert property (p_alert_on)
    else $error("alert not driven for an unmasked fault");
  property p_alert_off;
    live == 16'h0 |=> dev_alert_oe_n;
  endproperty
  a_alert_off: assert property (p_alert_off)
    else $error("alert driven while all faults are masked");
  property p_masked_quiet;
    fault != 16'h0 && (fault & ~auto_alert_mask) == 16'h0 |=> dev_alert_oe_n;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet)
    else $error("auto masked fault raised the alert");
  property p_auto_new;
    (auto_alert_mask & ~$past(auto_alert_mask) & ~$past(fault)) == 16'h0;
  endproperty
  a_auto_new: assert property (p_auto_new)
    else $error("auto mask bit set without a fault");
  property p_auto_grow;
    auto_alert_mask == 16'h0 ||
      (auto_alert_mask & $past(auto_alert_mask)) == $past(auto_alert_mask);
  endproperty
  a_auto_grow: assert property (p_auto_grow)
    else $error("auto mask partly cleared");
  property p_mask_reset;
    $rose(arst_n) |-> alert_mask == ALERT_MASK_RST && auto_alert_mask == 16'h0;
  endproperty
  a_mask_reset: assert property (p_mask_reset)
    else $error("masks not at reset value");
  property p_sda_scl_low;
    $changed(dev_sda_oe_n) |-> !scl;
  endproperty
  a_sda_scl_low: assert property (p_sda_scl_low)
    else $error("device changed data while clock high");
  property p_scl_stable;
    $changed(scl) |=> $stable(scl) [*8];
  endproperty
  a_scl_stable: assert property (p_scl_stable)
    else $error("bus clock phase too short");
  property p_drv_zero;
    dev_sda_out == 1'b0 && dev_alert_out == 1'b0;
  endproperty
  a_drv_zero: assert property (p_drv_zero)
    else $error("open drain output drives high");
  // A fresh auto mask with steady faults must release the alert next cycle.
  property p_ara_release;
    $changed(auto_alert_mask) && auto_alert_mask != 16'h0 && $stable(fault)
      |=> dev_alert_oe_n;
  endproperty
  a_ara_release: assert property (p_ara_release)
    else $error("alert kept after winning the alert response");
  // Main scenarios reached.
  c_alert: cover property (!dev_alert_oe_n);
  c_auto_set: cover property ($rose(|auto_alert_mask));
  c_auto_clr: cover property ($fell(|auto_alert_mask));
endmodule

// File: tb/tb.sv
// Purpose: Self-checking bench joining the host and device ends.
// Assumes: A single device on the link; register port on core_clk.
// Notes:   Expected values go to a queue that a monitor checks.
`timescale 1ns/1ns
module tb;
  import smbus_alert_pkg::*;
  typedef struct {logic [2:0] k; logic [15:0] v; logic [15:0] m;} note_s;
  logic        core_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, rd_d = 0;
  logic        irq, alert_active;
  logic [2:0]  strap_hi = 0, strap_lo = 0, reg_addr = 0;
  logic [15:0] fault = 0, reg_wdata = 0, reg_rdata, alert_mask, s, f, x;
  logic [15:0] auto_alert_mask;
  logic [6:0]  own_addr, ea;
  longint      v;
  int          n_mismatch = 0, num_checks = 0;
  note_s       q[$];

  smbus_link_if i_smbus_link_if ();
  smbus_alert_dev i_smbus_alert_dev (.core_clk, .arst_n, .strap_hi,
    .strap_lo, .fault, .own_addr, .alert_mask, .auto_alert_mask,
    .alert_active, .link(i_smbus_link_if));
  smbus_alert_host i_smbus_alert_host (.core_clk, .arst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .link(i_smbus_link_if));
  smbus_alert_checker i_smbus_alert_checker (.core_clk, .arst_n,
    .scl(i_smbus_link_if.scl), .dev_sda_out(i_smbus_link_if.dev_sda_out),
    .dev_sda_oe_n(i_smbus_link_if.dev_sda_oe_n),
    .dev_alert_out(i_smbus_link_if.dev_alert_out),
    .dev_alert_oe_n(i_smbus_link_if.dev_alert_oe_n),
    .fault, .alert_mask, .auto_alert_mask);

  // Free-running core clock.
  always #10 core_clk = ~core_clk;

  task automatic chk(input logic [15:0] got, input note_s e);
    num_checks++;
    if ((got & e.m) !== (e.v & e.m)) begin
      n_mismatch++;
      $display("unexpected at %0t: kind %0d got %h want %h",
               $time, e.k, got, e.v);
    end
  endtask

  // Takes the oldest note when its result shows and compares it.
  always @(posedge core_clk) begin
    rd_d <= reg_rd;
    if (q.size() > 0 && (rd_d || q[0].k != 3'd0)) begin
      case (q[0].k)
        3'd0: chk(reg_rdata, q[0]);
        3'd1: chk({15'h0, alert_active}, q[0]);
        3'd2: chk(alert_mask, q[0]);
        3'd3: chk(auto_alert_mask, q[0]);
        3'd4: chk({9'h0, own_addr}, q[0]);
        default: chk({15'h0, irq}, q[0]);
      endcase
      void'(q.pop_front());
    end
  end

  task automatic pn(input logic [2:0] k, input logic [15:0] e);
    repeat (3) @(posedge core_clk);
    q.push_back('{k, e, 16'hffff});
    // Lets the monitor take the note before any input moves again.
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [2:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    s = reg_rdata;
    @(posedge core_clk);
  endtask
  task automatic rc(input logic [2:0] a, input logic [15:0] e, m);
    q.push_back('{3'd0, e, m});
    rd(a);
  endtask
  // Starts a bus operation and polls until the host is idle again.
  task automatic op(input logic [1:0] o, input logic [6:0] a);
    int n;
    n = 0;
    wr(REG_CTRL, {7'h0, a, o});
    do begin
      rd(REG_STATUS);
      n++;
    end while ((s[0] !== 1'b0 || n < 2) && n < 20000);
    if (n >= 20000) begin
      n_mismatch++;
      $display("unexpected at %0t: host stays busy", $time);
    end
  endtask
  // Resets with strap pattern i and notes the decoded address.
  task automatic rst(input int i);
    int d;
    d = 1;
    for (int n = 0; n < 3; n++) begin
      strap_hi[n] <= ((i / d) % 3 == 2);
      strap_lo[n] <= ((i / d) % 3 == 1);
      d = d * 3;
    end
    ea = i < 8 ? 7'h40 + 7'(i) : i < 16 ? 7'h08 + 7'(i) : 7'h40 + 7'(i);
    arst_n <= 1'b0;
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    pn(3'd4, {9'h0, ea});
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    #1_800_000;
    n_mismatch++;
    wrap_up();
  end

  // Main sequence.
  initial begin
    void'($urandom(67949));
    for (int i = 0; i < 27; i++) rst(i);
    rst(int'($urandom % 27));
    f = (16'($urandom) & 16'h7ffe) | 16'h1;
    wr(REG_INT_MASK, 16'h2);
    fault <= f;
    pn(3'd1, 16'h1);
    repeat (6) @(posedge core_clk);
    pn(3'd5, 16'h1);
    rc(REG_INT_STAT, 16'h2, 16'h3);
    pn(3'd5, 16'h0);
    op(OP_ARA, ARA_ADDR);
    rc(REG_STATUS, {ea, 9'h0}, 16'hff05);
    pn(3'd3, f);
    pn(3'd1, 16'h0);
    pn(3'd5, 16'h0);
    rc(REG_INT_STAT, 16'h1, 16'h1);
    fault <= f | 16'h8000;
    pn(3'd1, 16'h1);
    fault <= f;
    pn(3'd1, 16'h0);
    op(OP_CLEAR, ea);
    pn(3'd3, 16'h0);
    pn(3'd1, 16'h1);
    wr(REG_DATA, f);
    op(OP_MASK, ea);
    pn(3'd2, f);
    pn(3'd1, 16'h0);
    x = 16'($urandom % 200);
    wr(REG_DATA, x);
    // Slope 22070, offset -1800 and exponent -2 in two's complement.
    wr(REG_SLOPE, 16'h5636);
    wr(REG_OFFS, 16'hf8f8);
    wr(REG_EXP, 16'h00fe);
    op(OP_VALUE, ea);
    v = (longint'(22070) * longint'(x) - 1800) / 100;
    pn(3'd2, v[15:0]);
    pn(3'd1, 16'(|(f & ~v[15:0])));
    repeat (2) @(posedge core_clk);
    wrap_up();
  end
endmodule
